// ==== core/host_port_device.sv ====
// device end of the host bus port: strobes, cycles, service acknowledge
`timescale 1ns/1ps
module host_port_device (
  input  wire logic             clk,
  input  wire logic             srst,
  host_bus_if.device            bus,
  input  wire logic [2:0]       carChannel,
  input  wire logic [2:0]       svcChannel,
  input  wire logic [2:0]       pending,
  input  wire logic [2:0][7:0]  matchVal,
  input  wire logic [2:0][7:0]  classVector,
  input  wire logic             chainEnable,
  input  wire logic [7:0]       regRdata,
  output logic                  regRead,
  output logic                  regWrite,
  output logic                  regGlobal,
  output logic [5:0]            regOffset,
  output logic [2:0]            regChannel,
  output logic [7:0]            regWdata,
  output logic [2:0]            inService,
  output logic                  eosPulse
);
  ////////////////////////////////////////////////////////////////////////////
  // strobe decode
  host_port_pkg::dev_state_t state_q, state_d;
  logic [1:0] rdWr;        // {read, write} from the shared pins
  logic       selected;    // strobe together with select or ack
  logic [2:0] hit;         // ack address matches per class
  // timing path shared by both styles
  assign rdWr = host_port_pkg::strobe_decode(bus.busStyleSelect,
                                             bus.strobeAN, bus.strobeBN);
  // select or ack qualifies the strobe
  assign selected = (rdWr[1] | rdWr[0]) & (~bus.csN | ~bus.serviceAckInN);
  // acknowledge byte compared with match values
  always_comb begin
    for (int c = 0; c < host_port_pkg::NUM_CLASS; c++) begin
      hit[c] = (matchVal[c] == bus.addr);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // cycle state
  logic       phase_q, phase_d;       // low = falling-edge sample slot
  logic       isWrite_q, isWrite_d;
  logic       isAck_q, isAck_d;       // acknowledge cycle
  logic       ackOwn_q, ackOwn_d;     // class granted in this cycle
  logic [1:0] ackCls_q, ackCls_d;
  logic [7:0] vector_q, vector_d;
  logic [7:0] dataOut_q, dataOut_d;
  logic       dataOe_q, dataOe_d;
  logic       dtackN_q, dtackN_d;
  logic       passN_q, passN_d;
  logic       rdP_q, rdP_d;
  logic       wrP_q, wrP_d;
  logic       glob_q, glob_d;
  logic [5:0] offs_q, offs_d;
  logic [2:0] chan_q, chan_d;
  logic [7:0] wdat_q, wdat_d;
  logic       eos_q, eos_d;
  logic [2:0] svc_q, svc_d;           // classes under service
  logic [2:0] hold_q, hold_d;         // request re-assert hold-off count
  logic [2:0] reqN_q, reqN_d;
  // next-state for the bus cycle and service bookkeeping
  always_comb begin
    state_d   = state_q;
    phase_d   = ~phase_q;
    isWrite_d = isWrite_q;
    isAck_d   = isAck_q;
    ackOwn_d  = ackOwn_q;
    ackCls_d  = ackCls_q;
    vector_d  = vector_q;
    dataOut_d = dataOut_q;
    dataOe_d  = dataOe_q;
    dtackN_d  = dtackN_q;
    passN_d   = passN_q;
    rdP_d     = 1'b0;
    wrP_d     = 1'b0;
    glob_d    = glob_q;
    offs_d    = offs_q;
    chan_d    = chan_q;
    wdat_d    = wdat_q;
    eos_d     = 1'b0;
    svc_d     = svc_q;
    hold_d    = (hold_q != 3'd0) ? hold_q - 3'd1 : hold_q;
    unique case (state_q)
      host_port_pkg::D_IDLE: begin
        // begin only at the falling-edge slot
        if (!phase_q && selected) begin
          isWrite_d = rdWr[0];
          isAck_d   = ~bus.serviceAckInN;
          ackOwn_d  = 1'b0;
          glob_d = bus.addr[host_port_pkg::GLOBAL_BIT];
          offs_d = bus.addr[5:0];
          // channel from access register unless servicing
          chan_d = (svc_q != 3'b000) ? svcChannel : carChannel;
          state_d = host_port_pkg::D_SETUP;
          if (~bus.serviceAckInN) begin
            // first matching class wins
            ackCls_d = hit[0] ? 2'd0 : (hit[1] ? 2'd1 : 2'd2);
            if (hit == 3'b000) begin
              state_d = host_port_pkg::D_IGNORE;
            end else if (pending[ackCls_d] && !svc_q[ackCls_d]) begin
              ackOwn_d = 1'b1;
              vector_d = classVector[ackCls_d];
            end else if (chainEnable) begin
              state_d = host_port_pkg::D_PASS;
              passN_d = 1'b0;
            end else begin
              vector_d = host_port_pkg::NULL_VECTOR;
            end
          end
        end
      end
      host_port_pkg::D_SETUP: begin
        // low half for setup, issue register read
        rdP_d   = ~isWrite_q & ~isAck_q;
        state_d = host_port_pkg::D_ACCESS;
      end
      host_port_pkg::D_ACCESS: begin
        if (isWrite_q) begin
          // host data captured as access half ends
          wrP_d  = 1'b1;
          wdat_d = bus.dataBus;
          eos_d  = glob_q && ({1'b1, offs_q} == host_port_pkg::EOS_ADDR);
        end else begin
          dataOut_d = isAck_q ? vector_q : regRdata;
          // read strobe acts as output enable
          dataOe_d  = rdWr[1] & selected;
        end
        // acknowledge within two clocks plus 10ns
        dtackN_d = 1'b0;
        state_d  = host_port_pkg::D_DONE;
      end
      host_port_pkg::D_DONE: begin
        // outputs off once strobe or select drops
        dataOe_d = ~isWrite_q & rdWr[1] & selected;
        if (!selected) begin
          dtackN_d = 1'b1;
          dataOe_d = 1'b0;
          // acknowledged class negated at cycle end
          if (ackOwn_q) begin
            svc_d[ackCls_q] = 1'b1;
          end
          state_d = host_port_pkg::D_IDLE;
        end
      end
      host_port_pkg::D_PASS: begin
        // pass output follows the incoming acknowledge
        if (bus.serviceAckInN) begin
          passN_d = 1'b1;
          state_d = host_port_pkg::D_IDLE;
        end
      end
      host_port_pkg::D_IGNORE: begin
        if (!selected) begin
          state_d = host_port_pkg::D_IDLE;
        end
      end
      default: begin
        state_d = host_port_pkg::D_IDLE;
      end
    endcase
    // end of service frees classes, hold-off before re-assert
    if (eos_q) begin
      svc_d  = 3'b000;
      hold_d = 3'(host_port_pkg::REASSERT_CYC);
    end
    // requests are combinational of pending but leave through flops
    for (int c = 0; c < host_port_pkg::NUM_CLASS; c++) begin
      reqN_d[c] = ~(pending[c] & ~svc_d[c] & (hold_d == 3'd0));
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q   <= host_port_pkg::D_IDLE;
      phase_q   <= 1'b0;
      isWrite_q <= 1'b0;
      isAck_q   <= 1'b0;
      ackOwn_q  <= 1'b0;
      ackCls_q  <= 2'd0;
      vector_q  <= 8'h00;
      dataOut_q <= 8'h00;
      dataOe_q  <= 1'b0;
      dtackN_q  <= 1'b1;
      passN_q   <= 1'b1;
      rdP_q     <= 1'b0;
      wrP_q     <= 1'b0;
      glob_q    <= 1'b0;
      offs_q    <= 6'h00;
      chan_q    <= 3'd0;
      wdat_q    <= 8'h00;
      eos_q     <= 1'b0;
      svc_q     <= 3'b000;
      hold_q    <= 3'd0;
      reqN_q    <= 3'b111;
    end else begin
      state_q   <= state_d;
      phase_q   <= phase_d;
      isWrite_q <= isWrite_d;
      isAck_q   <= isAck_d;
      ackOwn_q  <= ackOwn_d;
      ackCls_q  <= ackCls_d;
      vector_q  <= vector_d;
      dataOut_q <= dataOut_d;
      dataOe_q  <= dataOe_d;
      dtackN_q  <= dtackN_d;
      passN_q   <= passN_d;
      rdP_q     <= rdP_d;
      wrP_q     <= wrP_d;
      glob_q    <= glob_d;
      offs_q    <= offs_d;
      chan_q    <= chan_d;
      wdat_q    <= wdat_d;
      eos_q     <= eos_d;
      svc_q     <= svc_d;
      hold_q    <= hold_d;
      reqN_q    <= reqN_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign bus.dataDev              = dataOut_q;
  assign bus.dataDevOe            = dataOe_q;
  assign bus.transferAcknowledgeN = dtackN_q;
  assign bus.ackPassOutputN       = passN_q;
  assign bus.rxServiceReqN        = reqN_q[host_port_pkg::CLS_RX];
  assign bus.txServiceReqN        = reqN_q[host_port_pkg::CLS_TX];
  assign bus.modemServiceReqN     = reqN_q[host_port_pkg::CLS_MDM];
  assign regRead    = rdP_q;
  assign regWrite   = wrP_q;
  assign regGlobal  = glob_q;
  assign regOffset  = offs_q;
  assign regChannel = chan_q;
  assign regWdata   = wdat_q;
  assign inService  = svc_q;
  assign eosPulse   = eos_q;
endmodule // host_port_device

// ==== core/host_port_pkg.sv ====
// shared constants and state types for the host bus port
package host_port_pkg;
  localparam int DATA_W     = 8;   // register data path width
  localparam int ADDR_W     = 8;   // acknowledge address byte
  localparam int REG_AW     = 7;   // register address inputs
  localparam int GLOBAL_BIT = 6;   // high address input picks global space
  localparam int CHAN_W     = 3;   // channel number width
  localparam int NUM_CLASS  = 3;   // rx, tx, modem request classes
  localparam int CLS_RX     = 0;
  localparam int CLS_TX     = 1;
  localparam int CLS_MDM    = 2;
  // timing: one clk cycle is one half of the device system clock
  localparam int CLK_NS        = 25;
  localparam int SYS_CLK_NS    = 2 * CLK_NS;
  localparam int BUS_EXTRA_NS  = 10;
  localparam int ACK_MAX_CYC   = (2 * SYS_CLK_NS + BUS_EXTRA_NS) / CLK_NS;
  localparam int REASSERT_SYS  = 2;
  localparam int REASSERT_CYC  = REASSERT_SYS * SYS_CLK_NS / CLK_NS;
  localparam int HOST_TIMEOUT  = 64;
  // end-of-service register, global space offset
  localparam logic [REG_AW-1:0] EOS_ADDR    = 7'h60;
  localparam logic [DATA_W-1:0] NULL_VECTOR = 8'h00;
  localparam logic [DATA_W-1:0] FLOAT_VALUE = 8'hFF;
  typedef enum logic [2:0] {
    D_IDLE   = 3'b000,
    D_SETUP  = 3'b001,
    D_ACCESS = 3'b010,
    D_DONE   = 3'b011,
    D_PASS   = 3'b100,
    D_IGNORE = 3'b101
  } dev_state_t;
  typedef enum logic [1:0] {
    H_IDLE    = 2'b00,
    H_ADDR    = 2'b01,
    H_STROBE  = 2'b10,
    H_RELEASE = 2'b11
  } host_state_t;
  // strobe pins to {read, write}: style high = separate strobes
  function automatic logic [1:0] strobe_decode(input logic style,
                                               input logic pinA_n,
                                               input logic pinB_n);
    if (style)
      strobe_decode = {~pinA_n, ~pinB_n};
    else
      strobe_decode = {~pinA_n & pinB_n, ~pinA_n & ~pinB_n};
  endfunction
endpackage

// ==== core/host_bus_if.sv ====
// host bus wires joining the host end and the device end
`timescale 1ns/1ps
interface host_bus_if;
  logic       busStyleSelect;  // high: separate read/write strobes
  logic       csN;             // chip select
  logic       serviceAckInN;   // service acknowledge input
  logic       strobeAN;        // read strobe or data strobe
  logic       strobeBN;        // write strobe or direction
  logic [7:0] addr;            // address lines
  logic [7:0] dataHost;        // host data out
  logic       dataHostOe;      // host drives data
  logic [7:0] dataDev;         // device data out
  logic       dataDevOe;       // device drives data
  logic [7:0] dataBus;         // resolved data wire
  logic       transferAcknowledgeN;
  logic       ackPassOutputN;
  logic       rxServiceReqN;
  logic       txServiceReqN;
  logic       modemServiceReqN;
  // undriven bus floats high
  assign dataBus = dataDevOe ? dataDev :
                   dataHostOe ? dataHost : host_port_pkg::FLOAT_VALUE;
  modport device (
    input  busStyleSelect, csN, serviceAckInN, strobeAN, strobeBN,
    input  addr, dataBus,
    output dataDev, dataDevOe, transferAcknowledgeN, ackPassOutputN,
    output rxServiceReqN, txServiceReqN, modemServiceReqN
  );
  modport host (
    output busStyleSelect, csN, serviceAckInN, strobeAN, strobeBN,
    output addr, dataHost, dataHostOe,
    input  dataBus, transferAcknowledgeN, ackPassOutputN,
    input  rxServiceReqN, txServiceReqN, modemServiceReqN
  );
endinterface

// ==== core/host_port_host.sv ====
// host end of the host bus port: issues cycles and acknowledges
`timescale 1ns/1ps
module host_port_host #(
  parameter int TIMEOUT = host_port_pkg::HOST_TIMEOUT
) (
  input  wire logic        clk,
  input  wire logic        srst,
  host_bus_if.host         bus,
  input  wire logic        styleSel,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic        reqAck,
  input  wire logic [7:0]  reqAddr,
  input  wire logic [7:0]  reqWdata,
  output logic             reqReady,
  output logic             respValid,
  output logic [7:0]       respData,
  output logic             respError,
  output logic [2:0]       svcReqSync
);
  ////////////////////////////////////////////////////////////////////////////
  // cycle state
  host_port_pkg::host_state_t state_q, state_d;
  logic        wr_q, wr_d;          // current cycle writes
  logic        ack_q, ack_d;        // current cycle acknowledges
  logic [7:0]  addr_q, addr_d;
  logic [7:0]  wdat_q, wdat_d;
  logic        active_q, active_d;  // strobes asserted
  logic        csN_q, csN_d;
  logic        ackInN_q, ackInN_d;
  logic        ready_q, ready_d;
  logic        rv_q, rv_d;
  logic [7:0]  rdat_q, rdat_d;
  logic        err_q, err_d;
  logic [7:0]  tmo_q, tmo_d;        // no-answer watchdog
  logic [2:0]  sync1_q, sync2_q;    // request synchronisers
  // next state for the host cycle
  always_comb begin
    state_d  = state_q;
    wr_d     = wr_q;
    ack_d    = ack_q;
    addr_d   = addr_q;
    wdat_d   = wdat_q;
    active_d = active_q;
    csN_d    = csN_q;
    ackInN_d = ackInN_q;
    ready_d  = ready_q;
    rv_d     = 1'b0;
    rdat_d   = rdat_q;
    err_d    = 1'b0;
    tmo_d    = tmo_q;
    unique case (state_q)
      host_port_pkg::H_IDLE: begin
        if (reqValid && ready_q) begin
          ready_d = 1'b0;
          wr_d    = reqWrite & ~reqAck;
          ack_d   = reqAck;
          addr_d  = reqAddr;
          wdat_d  = reqWdata;
          tmo_d   = 8'(TIMEOUT);
          if (reqAck) begin
            // address settles a cycle before acknowledge
            state_d = host_port_pkg::H_ADDR;
          end else begin
            // chip select only, never with acknowledge
            csN_d    = 1'b0;
            active_d = 1'b1;
            state_d  = host_port_pkg::H_STROBE;
          end
        end
      end
      host_port_pkg::H_ADDR: begin
        ackInN_d = 1'b0;
        active_d = 1'b1;
        state_d  = host_port_pkg::H_STROBE;
      end
      host_port_pkg::H_STROBE: begin
        tmo_d = tmo_q - 8'd1;
        if (!bus.transferAcknowledgeN) begin
          // strobe held until data taken here
          rdat_d   = bus.dataBus;
          rv_d     = 1'b1;
          active_d = 1'b0;
          csN_d    = 1'b1;
          ackInN_d = 1'b1;
          state_d  = host_port_pkg::H_RELEASE;
        end else if (!bus.ackPassOutputN || tmo_q == 8'd0) begin
          // unanswered cycle flagged, not read as a vector
          err_d    = 1'b1;
          active_d = 1'b0;
          csN_d    = 1'b1;
          ackInN_d = 1'b1;
          state_d  = host_port_pkg::H_RELEASE;
        end
      end
      host_port_pkg::H_RELEASE: begin
        // wait for the device to let go of its answer
        if (bus.transferAcknowledgeN && bus.ackPassOutputN) begin
          ready_d = 1'b1;
          state_d = host_port_pkg::H_IDLE;
        end
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // registers; requests pass two flops before any use
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q  <= host_port_pkg::H_IDLE;
      wr_q     <= 1'b0;
      ack_q    <= 1'b0;
      addr_q   <= 8'h00;
      wdat_q   <= 8'h00;
      active_q <= 1'b0;
      csN_q    <= 1'b1;
      ackInN_q <= 1'b1;
      ready_q  <= 1'b1;
      rv_q     <= 1'b0;
      rdat_q   <= 8'h00;
      err_q    <= 1'b0;
      tmo_q    <= 8'h00;
      sync1_q  <= 3'b111;
      sync2_q  <= 3'b111;
    end else begin
      state_q  <= state_d;
      wr_q     <= wr_d;
      ack_q    <= ack_d;
      addr_q   <= addr_d;
      wdat_q   <= wdat_d;
      active_q <= active_d;
      csN_q    <= csN_d;
      ackInN_q <= ackInN_d;
      ready_q  <= ready_d;
      rv_q     <= rv_d;
      rdat_q   <= rdat_d;
      err_q    <= err_d;
      tmo_q    <= tmo_d;
      sync1_q  <= {bus.modemServiceReqN, bus.txServiceReqN, bus.rxServiceReqN};
      sync2_q  <= sync1_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin encoding
  // data strobe every cycle, direction low on writes
  // both strobes released together after acknowledge
  assign bus.busStyleSelect = styleSel;
  assign bus.strobeAN   = styleSel ? ~(active_q & ~wr_q) : ~active_q;
  assign bus.strobeBN   = styleSel ? ~(active_q & wr_q) : ~wr_q;
  assign bus.csN        = csN_q;
  assign bus.serviceAckInN = ackInN_q;
  // acknowledge byte on all eight address lines
  assign bus.addr       = addr_q;
  assign bus.dataHost   = wdat_q;
  assign bus.dataHostOe = active_q & wr_q;
  assign reqReady   = ready_q;
  assign respValid  = rv_q;
  assign respData   = rdat_q;
  assign respError  = err_q;
  assign svcReqSync = ~sync2_q;
endmodule // host_port_host

// ==== sim/host_bus_chk.sv ====
// concurrent checks on the wires between the host end and the device end
`timescale 1ns/1ps
module host_bus_chk (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       busStyleSelect,
  input wire logic       csN,
  input wire logic       serviceAckInN,
  input wire logic       strobeAN,
  input wire logic       strobeBN,
  input wire logic [7:0] dataDev,
  input wire logic       dataDevOe,
  input wire logic       transferAcknowledgeN,
  input wire logic       ackPassOutputN
);
  //////////////////////////////////////////////////////////////////////
  // selection decoded here on its own, so a slip in the design shows
  logic rdAct;  // read strobe active in either style
  logic sel;    // a strobe plus select or acknowledge
  assign rdAct = busStyleSelect ? ~strobeAN : ~strobeAN & strobeBN;
  assign sel = (busStyleSelect ? ~(strobeAN & strobeBN) : ~strobeAN) & ~(csN & serviceAckInN);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // acknowledge still low while the host keeps the cycle open
  sequence ackHeld;
    !transferAcknowledgeN && sel;
  endsequence
  // start of a plain chip-select cycle
  sequence selStart;
    $rose(sel && !csN);
  endsequence
  //////////////////////////////////////////////////////////////////////
  sel_excl_a: assert property (csN || serviceAckInN)
    else $error("select and acknowledge low together");
  ack_cause_a: assert property (!transferAcknowledgeN |-> $past(sel))
    else $error("acknowledge without selection");
  ack_time_a: assert property (selStart |-> ##[3:5] !transferAcknowledgeN)
    else $error("acknowledge late");
  ack_hold_a: assert property (ackHeld |=> !transferAcknowledgeN)
    else $error("acknowledge dropped early");
  ack_drop_a: assert property ($fell(sel) |=> transferAcknowledgeN)
    else $error("acknowledge kept after release");
  oe_read_a: assert property (dataDevOe |-> $past(rdAct && sel))
    else $error("data driven outside a read");
  data_hold_a: assert property (dataDevOe && $past(dataDevOe) |-> $stable(dataDev))
    else $error("read data moved while driven");
  ack_pass_excl_a: assert property (transferAcknowledgeN || ackPassOutputN)
    else $error("acknowledge and pass together");
  pass_cause_a: assert property (!ackPassOutputN |-> $past(!serviceAckInN))
    else $error("pass without acknowledge input");
endmodule // host_bus_chk

// ==== sim/host_bus_port_service_ack_test.sv ====
// self-checking bench: host end and device end joined by the bus interface
`timescale 1ns/1ps
module host_bus_port_service_ack_test;
  //////////////////////////////////////////////////////////////////////
  logic            clk = 1'h0;      // 40 MHz
  logic            srst = 1'h1;     // held 6 cycles
  int              failures = 0;    // mismatches
  int              tests_run = 0;   // comparisons
  int              cyc = 0;         // free cycle count
  int              eosCyc = 0;      // cycle of end-of-service pulse
  int              passCnt = 0;     // cycles with pass output low
  logic [2:0]      carChannel = 3'h5;
  logic [2:0]      svcChannel = 3'h2;
  logic [2:0]      pending = 3'h0;
  logic [2:0][7:0] matchVal = {8'h3C, 8'h2A, 8'h1E};
  logic [2:0][7:0] classVector = {8'h63, 8'h52, 8'h41};
  logic            chainEnable = 1'h0;
  logic [7:0]      regRdata = 8'hA5;
  logic            styleSel = 1'h1;
  logic            reqValid = 1'h0;
  logic            reqWrite = 1'h0;
  logic            reqAck = 1'h0;
  logic [7:0]      reqAddr = 8'h00;
  logic [7:0]      reqWdata = 8'h00;
  logic            reqReady, respValid, respError, regRead, regWrite, regGlobal, eosPulse;
  logic [7:0]      respData, regWdata, capWd;
  logic [2:0]      svcReqSync, regChannel, capCh, inService;
  logic [5:0]      regOffset, capOff;
  logic            capG;
  always #12.5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  host_bus_if bus ();
  // short timeout keeps unanswered acknowledges quick
  host_port_host #(.TIMEOUT(16)) u_host_port_host (.clk, .srst, .bus, .styleSel, .reqValid,
    .reqWrite, .reqAck, .reqAddr, .reqWdata, .reqReady, .respValid, .respData, .respError,
    .svcReqSync);
  host_port_device u_host_port_device (.clk, .srst, .bus, .carChannel, .svcChannel, .pending,
    .matchVal, .classVector, .chainEnable, .regRdata, .regRead, .regWrite, .regGlobal,
    .regOffset, .regChannel, .regWdata, .inService, .eosPulse);
  host_bus_chk u_host_bus_chk (.clk, .srst, .busStyleSelect(bus.busStyleSelect),
    .csN(bus.csN), .serviceAckInN(bus.serviceAckInN), .strobeAN(bus.strobeAN),
    .strobeBN(bus.strobeBN), .dataDev(bus.dataDev), .dataDevOe(bus.dataDevOe),
    .transferAcknowledgeN(bus.transferAcknowledgeN), .ackPassOutputN(bus.ackPassOutputN));
  //////////////////////////////////////////////////////////////////////
  // monitor: keeps the register-side fields of the last access
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (regRead || regWrite) begin
      capG <= regGlobal;
      capOff <= regOffset;
      capCh <= regChannel;
      capWd <= regWdata;
    end
    if (eosPulse) eosCyc <= cyc;
    if (bus.ackPassOutputN === 1'h0) passCnt <= passCnt + 1;
  end
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // the single place the run ends
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one request held until taken; bounded wait for the answer or error
  task automatic hostOp(input logic w, input logic a, input logic [7:0] ad,
                        input logic [7:0] wd, output int lat);
    @(posedge clk);
    #1;
    reqValid = 1'h1;
    reqWrite = w;
    reqAck = a;
    reqAddr = ad;
    reqWdata = wd;
    for (lat = 0; lat < 64 && reqReady !== 1'h1; lat++) begin
      @(posedge clk);
      #1;
    end
    // host never ready: counts as a mismatch
    if (lat >= 64) begin
      failures++;
      end_of_test();
    end
    @(posedge clk);
    #1;
    reqValid = 1'h0;
    for (lat = 1; lat < 64 && respValid !== 1'h1 && respError !== 1'h1; lat++) begin
      @(posedge clk);
      #1;
    end
    if (lat >= 64) begin
      failures++;
      end_of_test();
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  // writes and reads in both strobe styles; read latency may differ by at most one cycle between styles
  task automatic rwTest();
    int lat[2];
    for (int s = 0; s < 2; s++) begin
      styleSel = s[0];
      hostOp(1'h1, 1'h0, 8'h45, 8'h9C, lat[s]);
      chk(capWd, 8'h9C);
      chk({capG, 1'h0, capOff}, 8'h85);
      hostOp(1'h0, 1'h0, 8'h03, 8'h00, lat[s]);
      chk(respData, 8'hA5);
      chk({capG, 4'h0, capCh}, 8'h05);
    end
    chk({7'h0, (lat[0] - lat[1]) inside {-1, 0, 1}}, 8'h01);
  endtask
  // acknowledge cycles: hit, miss, chained and unchained invalid
  task automatic ackTest();
    int lat;
    int p0;
    pending = 3'h2;
    styleSel = 1'h0;
    repeat (8) @(posedge clk);
    #1;
    chk({7'h0, bus.txServiceReqN}, 8'h00);
    hostOp(1'h0, 1'h1, 8'h2A, 8'h00, lat);
    chk({respError, respData[6:0]}, 8'h52);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h0, bus.txServiceReqN}, 8'h01);
    chk({5'h0, inService}, 8'h02);
    p0 = passCnt;
    hostOp(1'h0, 1'h1, 8'h77, 8'h00, lat);
    chk({6'h0, respError, passCnt != p0}, 8'h02);
    chainEnable = 1'h1;
    p0 = passCnt;
    hostOp(1'h0, 1'h1, 8'h1E, 8'h00, lat);
    chk({6'h0, respError, passCnt != p0}, 8'h03);
    chainEnable = 1'h0;
    hostOp(1'h0, 1'h1, 8'h3C, 8'h00, lat);
    chk({respError, respData[6:0]}, 8'h00);
  endtask
  // end-of-service write: request stays off for the reassert delay
  task automatic eosTest();
    int n;
    hostOp(1'h1, 1'h0, 8'h60, 8'h00, n);
    for (n = 0; n < 64 && bus.txServiceReqN !== 1'h0; n++) begin
      @(posedge clk);
      #1;
    end
    // request never came back: counts as a mismatch
    if (n >= 64) begin
      failures++;
      end_of_test();
    end
    n = cyc - eosCyc - host_port_pkg::REASSERT_CYC;
    chk({7'h0, n inside {[0:2]}}, 8'h01);
    chk({5'h0, inService}, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk({5'h0, svcReqSync}, 8'h02);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    #1;
    srst = 1'h0;
    rwTest();
    ackTest();
    eosTest();
    end_of_test();
  end
endmodule // host_bus_port_service_ack_test
